//--- uct_top.sv
// control-two register block of the serial unit with its AXI4-Lite slave
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module uct_top #(
  parameter int ADDR_W = uct_pkg::UCT_ADDR_W
) (
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // status logic and frame shifter
  input  wire uct_pkg::uct_flags_t flags,
  input  wire uct_pkg::uct_txh_t   txh,
  input  wire logic                wake,
  input  wire logic                tx_serial,
  // serial pins
  input  wire logic                txd_level,
  output logic                     txd_drv,
  output logic                     txd_oe,
  input  wire logic                rxd_level,
  // controls toward the rest of the unit
  output logic                     xmit_on,
  output logic                     rcv_on,
  output logic                     rcv_standby,
  output logic                     idle_req,
  output logic                     brk_req,
  output logic                     tx_done_flag,
  output logic                     rx_bit,
  output logic                     rxd_owned,
  output logic                     irq
);
  import uct_pkg::*;

  if (ADDR_W < UCT_ADDR_W) begin : g_chk
    $error("uct_top address width too small for the register map");
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]           ctrl_q;
  logic [UCT_CFG_W-1:0] cfg_q;
  logic [UCT_ST_W-1:0]  sts_q;
  logic [UCT_ST_W-1:0]  mask_q;
  logic                 idle_req_q;
  logic                 brk_req_q;
  logic                 tx_done_q;
  logic                 irq_q;
  logic                 txd_drv_q;
  logic                 txd_oe_q;
  logic                 rx_bit_q;
  logic                 rxd_owned_q;
  uct_txp_t             txp_q;
  uct_txp_t             txp_d;

  // bus slave state
  logic                 awready_q;
  logic                 wready_q;
  logic                 aw_hold_q;
  logic                 w_hold_q;
  logic [ADDR_W-1:0]    awaddr_q;
  logic [31:0]          wdata_q;
  logic                 wstrb0_q;
  logic                 bvalid_q;
  logic [1:0]           bresp_q;
  logic                 arready_q;
  logic                 rvalid_q;
  logic [31:0]          rdata_q;
  logic [1:0]           rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] pin_lv;

  uct_sync #(
    .W   (2),
    .RST (2'h3)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     ({txd_level, rxd_level}),
    .level   (pin_lv)
  );

  wire txd_sync = pin_lv[1];
  wire rxd_sync = pin_lv[0];

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  wire aw_take = s_axi_awvalid & awready_q;
  wire w_take  = s_axi_wvalid & wready_q;
  wire wr_do   = aw_hold_q & w_hold_q & ~bvalid_q;
  wire b_done  = bvalid_q & s_axi_bready;

  wire [4:0] wa     = awaddr_q[4:0];
  wire       wa_hi  = (ADDR_W > UCT_ADDR_W) ? |(awaddr_q >> UCT_ADDR_W) : 1'b0;
  wire       w_cfg  = !wa_hi && wa == UCT_A_CFG;
  wire       w_ctl  = !wa_hi && wa == UCT_A_CTRL2;
  wire       w_sts  = !wa_hi && wa == UCT_A_STS;
  wire       w_msk  = !wa_hi && wa == UCT_A_MASK;
  wire       w_st   = !wa_hi && wa == UCT_A_STATE;
  wire       w_hit  = w_cfg | w_ctl | w_sts | w_msk | w_st;
  wire       wr_en  = wr_do & wstrb0_q;
  wire       wr_ctl = wr_en & w_ctl;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb0_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= UCT_RESP_OKAY;
    end else begin
      if (aw_take) begin
        awaddr_q  <= s_axi_awaddr;
        aw_hold_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (w_take) begin
        wdata_q  <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
        w_hold_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_do) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= w_hit ? UCT_RESP_OKAY : UCT_RESP_SLV;
      end
      if (b_done) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel: one cycle from address to data, no wait on block state
  wire ar_take = s_axi_arvalid & arready_q;
  wire r_done  = rvalid_q & s_axi_rready;

  wire [4:0] ra    = s_axi_araddr[4:0];
  wire       ra_hi = (ADDR_W > UCT_ADDR_W) ? |(s_axi_araddr >> UCT_ADDR_W) : 1'b0;
  wire       r_cfg = !ra_hi && ra == UCT_A_CFG;
  wire       r_ctl = !ra_hi && ra == UCT_A_CTRL2;
  wire       r_sts = !ra_hi && ra == UCT_A_STS;
  wire       r_msk = !ra_hi && ra == UCT_A_MASK;
  wire       r_st  = !ra_hi && ra == UCT_A_STATE;
  wire       r_hit = r_cfg | r_ctl | r_sts | r_msk | r_st;

  wire [7:0] state_rd = {3'h0, rxd_owned_q, txd_oe_q, brk_req_q, idle_req_q, tx_done_q};
  wire [31:0] rd_mux =
      r_cfg ? {29'h0, cfg_q}  :
      r_ctl ? {24'h0, ctrl_q} :
      r_sts ? {28'h0, sts_q}  :
      r_msk ? {28'h0, mask_q} :
      r_st  ? {24'h0, state_rd} : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= UCT_RESP_OKAY;
    end else if (ar_take) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_mux;
      rresp_q   <= r_hit ? UCT_RESP_OKAY : UCT_RESP_SLV;
    end else if (r_done) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control-two and configuration
  wire       xon_now  = ctrl_q[UCT_B_XON];
  wire       tx_act   = txh.busy | idle_req_q | brk_req_q;
  wire       xon_rise = wr_ctl & wdata_q[UCT_B_XON] & ~xon_now;
  // a software set of standby beats a wakeup in the same cycle
  wire       stby_d   = wr_ctl ? wdata_q[UCT_B_STBY]
                               : ctrl_q[UCT_B_STBY] & ~wake;
  wire [7:0] ctrl_wv  = wr_ctl ? wdata_q[7:0] : ctrl_q;
  wire [7:0] ctrl_d   = {ctrl_wv[7:2], stby_d, ctrl_wv[0]};
  wire       single   = cfg_q[UCT_C_WRAP] & cfg_q[UCT_C_SRC];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= UCT_CTRL2_RST;
      cfg_q  <= UCT_CFG_RST;
      mask_q <= UCT_ST_RST;
    end else begin
      ctrl_q <= ctrl_d;
      if (wr_en && w_cfg) begin
        cfg_q <= wdata_q[UCT_CFG_W-1:0];
      end
      if (wr_en && w_msk) begin
        mask_q <= wdata_q[UCT_ST_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // idle and break queueing, transmit-done flag
  // a pending break stays until the shifter takes it, even if software lets go
  wire idle_d  = (xon_rise & tx_act) | (idle_req_q & ~txh.idle_ack);
  wire brk_d   = ctrl_q[UCT_B_BRK] | (brk_req_q & ~txh.brk_ack);
  wire tdone_d = flags.xbe & ~tx_act;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_req_q <= 1'b0;
      brk_req_q  <= 1'b0;
      tx_done_q  <= 1'b1;
    end else begin
      idle_req_q <= idle_d;
      brk_req_q  <= brk_d;
      tx_done_q  <= tdone_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit pin ownership
  always_comb begin
    txp_d = txp_q;
    case (txp_q)
      UCT_TXP_OFF: begin
        if (xon_now) begin
          txp_d = UCT_TXP_ON;
        end
      end
      UCT_TXP_ON: begin
        if (!xon_now) begin
          txp_d = tx_act ? UCT_TXP_DRAIN : UCT_TXP_OFF;
        end
      end
      UCT_TXP_DRAIN: begin
        if (xon_now) begin
          txp_d = UCT_TXP_ON;
        end else if (!tx_act) begin
          txp_d = UCT_TXP_OFF;
        end
      end
      default: begin
        txp_d = UCT_TXP_OFF;
      end
    endcase
  end

  // in single-wire mode the direction bit turns the shared pin around
  wire pin_own = txp_d != UCT_TXP_OFF;
  wire oe_d    = pin_own & (~single | cfg_q[UCT_C_DIR]);

  ////////////////////////////////////////////////////////////////////////////
  // receive path
  wire loop_src = cfg_q[UCT_C_SRC] ? txd_sync : tx_serial;
  wire rx_src   = cfg_q[UCT_C_WRAP] ? loop_src : rxd_sync;
  wire rx_d     = ctrl_q[UCT_B_RON] ? rx_src : 1'b1;
  wire rown_d   = ctrl_q[UCT_B_RON] & ~cfg_q[UCT_C_WRAP];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txp_q       <= UCT_TXP_OFF;
      txd_oe_q    <= 1'b0;
      txd_drv_q   <= 1'b1;
      rx_bit_q    <= 1'b1;
      rxd_owned_q <= 1'b0;
    end else begin
      txp_q       <= txp_d;
      txd_oe_q    <= oe_d;
      txd_drv_q   <= tx_serial;
      rx_bit_q    <= rx_d;
      rxd_owned_q <= rown_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: flag enables plus sticky events under the mask
  logic tdone_prev_q;
  wire irq_xbe   = ctrl_q[UCT_B_XBE] & flags.xbe;
  wire irq_tdn   = ctrl_q[UCT_B_TDN] & tx_done_q;
  wire irq_rxf   = ctrl_q[UCT_B_RXF] & flags.rcv_full;
  wire irq_quiet = ctrl_q[UCT_B_QUIET] & flags.quiet;
  wire irq_flag  = irq_xbe | irq_tdn | irq_rxf | irq_quiet;

  wire [UCT_ST_W-1:0] ev;
  assign ev[UCT_ST_TDONE] = tx_done_q & ~tdone_prev_q;
  assign ev[UCT_ST_WAKE]  = ctrl_q[UCT_B_STBY] & wake;
  assign ev[UCT_ST_BRK]   = brk_req_q & txh.brk_ack;
  assign ev[UCT_ST_IDLE]  = idle_req_q & txh.idle_ack;

  // write-one-to-clear; an event in the clearing cycle survives
  wire [UCT_ST_W-1:0] st_clr = (wr_en && w_sts) ? wdata_q[UCT_ST_W-1:0] : UCT_ST_RST;
  wire [UCT_ST_W-1:0] sts_d  = (sts_q & ~st_clr) | ev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts_q        <= UCT_ST_RST;
      tdone_prev_q <= 1'b1;
      irq_q        <= 1'b0;
    end else begin
      sts_q        <= sts_d;
      tdone_prev_q <= tx_done_q;
      irq_q        <= irq_flag | |(sts_q & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign xmit_on       = ctrl_q[UCT_B_XON];
  assign rcv_on        = ctrl_q[UCT_B_RON];
  assign rcv_standby   = ctrl_q[UCT_B_STBY];
  assign idle_req      = idle_req_q;
  assign brk_req       = brk_req_q;
  assign tx_done_flag  = tx_done_q;
  assign txd_drv       = txd_drv_q;
  assign txd_oe        = txd_oe_q;
  assign rx_bit        = rx_bit_q;
  assign rxd_owned     = rxd_owned_q;
  assign irq           = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_ctrl_write: assert property (wr_ctl |=> ctrl_q[7:2] == $past(wdata_q[7:2]))
    else $error("control-two write not stored");
  a_irq_xbe: assert property (ctrl_q[UCT_B_XBE] && flags.xbe |=> irq_q)
    else $error("buffer-empty interrupt missing");
  a_irq_tdone: assert property (ctrl_q[UCT_B_TDN] && tx_done_q |=> irq_q)
    else $error("transmit-done interrupt missing");
  a_irq_rxfull: assert property (ctrl_q[UCT_B_RXF] && flags.rcv_full |=> irq_q)
    else $error("receive-full interrupt missing");
  a_irq_quiet: assert property (ctrl_q[UCT_B_QUIET] && flags.quiet |=> irq_q)
    else $error("quiet-line interrupt missing");
  a_irq_masked: assert property (!irq_flag && !(|(sts_q & mask_q)) |=> !irq_q)
    else $error("interrupt without enabled source");
  a_pin_owned: assert property (xon_now && !single |=> txd_oe_q)
    else $error("transmit pin not driven while enabled");
  a_wire_dir: assert property (single && !cfg_q[UCT_C_DIR] |=> !txd_oe_q)
    else $error("single-wire pin driven in receive direction");
  a_idle_queue: assert property (xon_rise && tx_act |=> idle_req_q)
    else $error("idle character not queued");
  a_pin_drain: assert property ($fell(xon_now) && tx_act && !single |=> txd_oe_q)
    else $error("pin released before traffic finished");
  a_rxd_release: assert property (cfg_q[UCT_C_WRAP] || !ctrl_q[UCT_B_RON] |=> !rxd_owned_q)
    else $error("input pin kept while released");
  a_standby_set: assert property (wr_ctl && wdata_q[UCT_B_STBY] |=> rcv_standby)
    else $error("standby not entered");
  a_brk_repeat: assert property (brk_req_q && txh.brk_ack && ctrl_q[UCT_B_BRK]
                                 ##1 ctrl_q[UCT_B_BRK] |=> brk_req_q)
    else $error("further break not queued");
  a_tdone_flag: assert property (flags.xbe && !tx_act |=> tx_done_q)
    else $error("transmit-done flag not set");

  c_idle_queued: cover property (xon_rise && tx_act ##1 idle_req_q);
  c_break_taken: cover property (brk_req_q && txh.brk_ack);
  c_irq_rise:    cover property (!irq_q ##1 irq_q);
  c_pin_drain:   cover property (txp_q == UCT_TXP_DRAIN ##1 txp_q == UCT_TXP_OFF);

endmodule

//--- uct_pkg.sv
// shared constants, field positions and carrier types for the control-two block
package uct_pkg;

  // register map: the control-two register sits at word index 3
  localparam int          UCT_ADDR_W     = 5;
  localparam int          UCT_CTRL2_IDX  = 3;
  localparam logic [4:0]  UCT_A_CFG      = 5'h00;
  localparam logic [4:0]  UCT_A_CTRL2    = 5'(UCT_CTRL2_IDX * 4);
  localparam logic [4:0]  UCT_A_STS      = 5'h10;
  localparam logic [4:0]  UCT_A_MASK     = 5'h14;
  localparam logic [4:0]  UCT_A_STATE    = 5'h18;

  // control-two fields
  localparam int          UCT_B_XBE      = 7;
  localparam int          UCT_B_TDN      = 6;
  localparam int          UCT_B_RXF      = 5;
  localparam int          UCT_B_QUIET    = 4;
  localparam int          UCT_B_XON      = 3;
  localparam int          UCT_B_RON      = 2;
  localparam int          UCT_B_STBY     = 1;
  localparam int          UCT_B_BRK      = 0;
  localparam logic [7:0]  UCT_CTRL2_RST  = 8'h00;

  // link configuration fields
  localparam int          UCT_CFG_W      = 3;
  localparam int          UCT_C_WRAP     = 0;
  localparam int          UCT_C_SRC      = 1;
  localparam int          UCT_C_DIR      = 2;
  localparam logic [2:0]  UCT_CFG_RST    = 3'h0;

  // sticky event status, same layout as the mask
  localparam int          UCT_ST_W       = 4;
  localparam int          UCT_ST_TDONE   = 0;
  localparam int          UCT_ST_WAKE    = 1;
  localparam int          UCT_ST_BRK     = 2;
  localparam int          UCT_ST_IDLE    = 3;
  localparam logic [3:0]  UCT_ST_RST     = 4'h0;

  localparam logic [1:0]  UCT_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  UCT_RESP_SLV   = 2'h2;

  // flags produced by the status logic, same clock
  typedef struct packed {
    logic xbe;
    logic rcv_full;
    logic quiet;
  } uct_flags_t;

  // handshake from the frame shifter, same clock
  typedef struct packed {
    logic busy;
    logic idle_ack;
    logic brk_ack;
  } uct_txh_t;

  // ownership of the transmit pin
  typedef enum logic [1:0] {
    UCT_TXP_OFF   = 2'b00,
    UCT_TXP_ON    = 2'b01,
    UCT_TXP_DRAIN = 2'b11
  } uct_txp_t;

endpackage

//--- uct_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module uct_sync #(
  parameter int         W   = 2,
  parameter logic [1:0] RST = 2'h3
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // pins and filtered levels
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);

  if (W < 1 || W > 2) begin : g_chk
    $error("uct_sync width must be 1 or 2");
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lv_q;
    // the first stage feeds only the second, so no gate sees a metastable level
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        s1_q <= RST[i];
        s2_q <= RST[i];
        s3_q <= RST[i];
        lv_q <= RST[i];
      end else begin
        s1_q <= pin[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
          lv_q <= s3_q;
        end
      end
    end
    assign level[i] = lv_q;
  end

endmodule

//--- uct_peer.sv
// frame shifter and remote line model facing the control-two block
`timescale 1ns/1ps
module uct_peer
  import uct_pkg::*;
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // requests and pin from the block, speed and remote line from the bench
  input  wire logic idle_req,
  input  wire logic brk_req,
  input  wire logic txd_drv,
  input  wire logic txd_oe,
  input  wire logic slow,
  input  wire logic rx_line,
  // shifter side
  output uct_txh_t  txh,
  output logic      tx_serial,
  output logic      txd_level,
  output logic      rxd_level
);
  logic [4:0] cnt_q;
  logic       brk_q;
  logic       iack_q;
  logic       back_q;

  // a break wins over a queued idle, as a slow shifter would pick it first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q  <= 5'h0;
      brk_q  <= 1'b0;
      iack_q <= 1'b0;
      back_q <= 1'b0;
    end else begin
      iack_q <= 1'b0;
      back_q <= 1'b0;
      if (cnt_q != 5'h0) begin
        cnt_q <= cnt_q - 5'h1;
      end else if (brk_req || idle_req) begin
        cnt_q  <= slow ? 5'h14 : 5'h2;
        brk_q  <= brk_req;
        back_q <= brk_req;
        iack_q <= !brk_req;
      end
    end
  end

  assign txh       = '{busy: cnt_q != 5'h0, idle_ack: iack_q, brk_ack: back_q};
  assign tx_serial = !(cnt_q != 5'h0 && brk_q);
  // line has a pull-up, so a released pin reads high
  assign txd_level = txd_oe ? txd_drv : 1'b1;
  assign rxd_level = rx_line;
endmodule

//--- uart_control_two_enables_tb.sv
// self-checking bench of the control-two block
`timescale 1ns/1ps
module uart_control_two_enables_tb;
  import uct_pkg::*;
  logic aclk = 0, aresetn = 0, wake = 0, rx_line = 1, slow = 0;
  logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  uct_flags_t flags = 3'b100;
  uct_txh_t txh;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata;
  logic tx_serial, txd_level, txd_drv, txd_oe, rxd_level, xmit_on, rcv_on, rcv_standby;
  logic idle_req, brk_req, tx_done_flag, rx_bit, rxd_owned, irq;
  logic [15:0] rnd = 16'hC82F;
  int errors = 0, tests_run = 0, acks = 0, n, i;

  uct_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flags, .txh, .wake,
    .tx_serial, .txd_level, .txd_drv, .txd_oe, .rxd_level, .xmit_on, .rcv_on,
    .rcv_standby, .idle_req, .brk_req, .tx_done_flag, .rx_bit, .rxd_owned, .irq);
  uct_peer i_peer (.aclk, .aresetn, .idle_req, .brk_req, .txd_drv, .txd_oe, .slow,
    .rx_line, .txh, .tx_serial, .txd_level, .rxd_level);

  always #10 aclk = ~aclk;
  always @(posedge aclk) if (txh.brk_ack) acks <= acks + 1;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic conclude;
    $display("tests %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bound(input int k);
    if (k >= 200) begin
      errors++;
      conclude();
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    bound(n);
    r = s_axi_bresp; s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    bound(n);
    d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(5); aresetn <= 1; tick(1);
    chk("tdone_rst", 1, tx_done_flag);
    rd(UCT_A_CTRL2);
    chk("ctrl2_rst", UCT_CTRL2_RST, d);
    rd(5'h1C);
    chk("rresp_unmapped", UCT_RESP_SLV, r);
    chk("rdata_unmapped", 0, d);
    wr(5'h1C, 8'hFF);
    chk("bresp_unmapped", UCT_RESP_SLV, r);
    repeat (8) begin
      rnd = lfsr(rnd);
      wr(UCT_A_CTRL2, rnd[7:0] & 8'hF4);
      chk("bresp_ok", UCT_RESP_OKAY, r);
      rd(UCT_A_CTRL2);
      chk("ctrl2_rw", rnd[7:0] & 8'hF4, d);
    end
    $display("test register access done");
    for (i = 0; i < 4; i++) begin
      flags <= (i < 2) ? 3'b100 : (i == 2 ? 3'b010 : 3'b001);
      wr(UCT_A_CTRL2, 8'h80 >> i); tick(3);
      chk("irq_on", 1, irq);
      flags <= 3'b000; tick(3);
      chk("irq_level", 0, irq);
      flags <= (i < 2) ? 3'b100 : (i == 2 ? 3'b010 : 3'b001);
      wr(UCT_A_CTRL2, 8'h00); tick(3);
      chk("irq_off", 0, irq);
    end
    flags <= 3'b000; tick(2); wr(UCT_A_STS, 8'h0F); wr(UCT_A_MASK, 8'h01);
    flags <= 3'b100; tick(4);
    chk("sts_irq", 1, irq);
    rd(UCT_A_STS);
    chk("sts_bit", 1, d[0]);
    wr(UCT_A_STS, 8'h01); tick(2);
    chk("sts_clr", 0, irq);
    wr(UCT_A_MASK, 8'h00);
    $display("test interrupts done");
    wr(UCT_A_CTRL2, 8'h08); tick(2);
    chk("txd_oe_on", 1, txd_oe);
    chk("xmit_on", 1, xmit_on);
    chk("txd_drv_idle", 1, txd_drv);
    rd(UCT_A_STATE);
    chk("state_oe", 1, d[3]);
    wr(UCT_A_CTRL2, 8'h09); tick(60);
    chk("break_repeat", 1, acks >= 2);
    chk("brk_req", 1, brk_req);
    // slow shifter first, so the break still pending at the clear runs long
    slow <= 1;
    wr(UCT_A_CTRL2, 8'h08); tick(10);
    for (n = 0; n < 200 && !txh.busy; n++) @(posedge aclk);
    bound(n);
    chk("tdone_busy", 0, tx_done_flag);
    wr(UCT_A_CTRL2, 8'h00); tick(1);
    chk("txd_oe_drain", 1, txd_oe);
    wr(UCT_A_CTRL2, 8'h08);
    for (n = 0; n < 200 && !idle_req; n++) @(posedge aclk);
    chk("idle_queued", 1, idle_req);
    wr(UCT_A_CTRL2, 8'h00);
    for (n = 0; n < 200 && txd_oe; n++) @(posedge aclk);
    chk("txd_released", 0, txd_oe);
    wr(UCT_A_CTRL2, 8'h08); wr(UCT_A_CFG, 8'h03); tick(2);
    chk("one_wire_in", 0, txd_oe);
    wr(UCT_A_CFG, 8'h07); tick(2);
    chk("one_wire_out", 1, txd_oe);
    $display("test transmitter done");
    wr(UCT_A_CFG, 8'h00); wr(UCT_A_CTRL2, 8'h04); rx_line <= 0; tick(6);
    chk("rxd_owned", 1, rxd_owned);
    chk("rcv_on", 1, rcv_on);
    chk("rx_bit_pin", 0, rx_bit);
    wr(UCT_A_CFG, 8'h01); tick(3);
    chk("wrap_owned", 0, rxd_owned);
    chk("wrap_bit", 1, rx_bit);
    wr(UCT_A_CFG, 8'h00); wr(UCT_A_CTRL2, 8'h00); tick(3);
    chk("rcv_off_bit", 1, rx_bit);
    wr(UCT_A_CTRL2, 8'h02); tick(1);
    chk("standby_set", 1, rcv_standby);
    wake <= 1; tick(1); wake <= 0; tick(2);
    chk("standby_wake", 0, rcv_standby);
    $display("test receiver done");
    conclude();
  end
  initial begin
    tick(100000);
    errors++;
    conclude();
  end
endmodule
